// ---- design/led_pin_pkg.sv ----
// Shared constants and types for the LED blink and pin select block
`default_nettype none
package led_pin_pkg;

  // Configuration register index and layout
  localparam logic [7:0] SEL2_INDEX    = 8'h2a;
  localparam logic [7:0] SEL2_RESET    = 8'h00;
  // Bit 0 is not defined here: writes ignored, reads zero
  localparam logic [7:0] SEL2_WMASK    = 8'hfe;
  localparam int         STBY_MODE_HI  = 7;
  localparam int         STBY_MODE_LO  = 6;
  localparam int         MAIN_MODE_HI  = 5;
  localparam int         MAIN_MODE_LO  = 4;
  localparam int         RSM_SEL_BIT   = 3;
  localparam int         PG_SEL_BIT    = 2;
  localparam int         SON_SEL_BIT   = 1;
  // Pin select bits form one contiguous field starting at bit 1
  localparam int         PIN_COUNT     = 3;
  localparam int         PIN_SEL_LO    = SON_SEL_BIT;

  // LED output modes
  typedef enum logic [1:0] {
    LED_LOW  = 2'b00,
    LED_HIZ  = 2'b01,
    LED_SLOW = 2'b10,
    LED_FAST = 2'b11
  } led_mode_t;

  // Blink timing: one shared tick per half period of the 1 Hz wave
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_1HZ_NS   = 500000000;
  localparam int TICK_CYC      = HALF_1HZ_NS / CLK_PERIOD_NS;

  // Configuration access request
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cfg_req_t;

  // One LED pad: level and active-low output enable
  typedef struct packed {
    logic level;
    logic oe_n;
  } led_pin_t;

endpackage
`default_nettype wire

// ---- design/blink_timebase.sv ----
// Shared divided time base producing the 1 Hz and 0.5 Hz phases
`timescale 1ns/10ps
`default_nettype none
module blink_timebase #(
  parameter int TICK_CYC = led_pin_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Phases
  output logic      phase_fast,
  output logic      phase_slow
);
  import led_pin_pkg::*;

  localparam int CW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);

  logic [CW-1:0] count_r;
  logic          fast_r;
  logic          slow_r;
  logic          tick;

  assign tick = (count_r == LAST);

  // Free-running divider; one counter feeds both rates
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (tick) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + 1'b1;
    end
  end

  // Slow phase toggles on every second tick, so edges stay aligned
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fast_r <= 1'b0;
      slow_r <= 1'b0;
    end else if (tick) begin
      fast_r <= ~fast_r;
      if (fast_r) begin
        slow_r <= ~slow_r;
      end
    end
  end

  assign phase_fast = fast_r;
  assign phase_slow = slow_r;

  // Slow phase only moves together with a falling fast phase
  property p_slow_follows_fast;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(slow_r) |-> $fell(fast_r);
  endproperty
  a_slow_follows_fast: assert property (p_slow_follows_fast)
    else $error("slow blink phase moved without fast phase falling");

endmodule
`default_nettype wire

// ---- design/pin_route.sv ----
// Dedicated function or general I/O routing for the multiplexed pins
`timescale 1ns/10ps
`default_nettype none
module pin_route #(
  parameter int N = led_pin_pkg::PIN_COUNT
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Select, one bit per pin, set means general I/O
  input  wire logic [N-1:0] gp_sel,
  // Dedicated function side
  input  wire logic [N-1:0] func_o,
  input  wire logic [N-1:0] func_oe_n,
  output logic      [N-1:0] func_i,
  // General I/O side
  input  wire logic [N-1:0] gpio_o,
  input  wire logic [N-1:0] gpio_oe_n,
  output logic      [N-1:0] gpio_i,
  // Pad side
  input  wire logic [N-1:0] pad_i,
  output logic      [N-1:0] pad_o,
  output logic      [N-1:0] pad_oe_n
);

  for (genvar i = 0; i < N; i++) begin : g_pin
    // Registered so pads never see a combinational glitch on reselect
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        pad_o[i]    <= 1'b0;
        pad_oe_n[i] <= 1'b1;
        func_i[i]   <= 1'b1;
        gpio_i[i]   <= 1'b1;
      end else begin
        pad_o[i]    <= gp_sel[i] ? gpio_o[i] : func_o[i];
        pad_oe_n[i] <= gp_sel[i] ? gpio_oe_n[i] : func_oe_n[i];
        // Deselected side sees an idle high level
        func_i[i]   <= gp_sel[i] ? 1'b1 : pad_i[i];
        gpio_i[i]   <= gp_sel[i] ? pad_i[i] : 1'b1;
      end
    end

    // First edge after reset still shows reset values, so skip it
    property p_pin_owner;
      @(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && $past(gp_sel[i])
          |-> (pad_o[i] == $past(gpio_o[i]))
           && (pad_oe_n[i] == $past(gpio_oe_n[i]));
    endproperty
    a_pin_owner: assert property (p_pin_owner)
      else $error("general I/O selected but pad not driven from it");

    property p_pin_func;
      @(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && !$past(gp_sel[i])
          |-> (pad_o[i] == $past(func_o[i]))
           && (gpio_i[i] == 1'b1);
    endproperty
    a_pin_func: assert property (p_pin_func)
      else $error("dedicated function selected but pad not owned by it");
  end

endmodule
`default_nettype wire

// ---- design/led_blink_pin_select.sv ----
// Top: select register, LED blink drivers and pin routing
// Notes on behaviour
// - Standby LED mode sits in bits 7:6, read/write, resets to 00.
// - Standby mode 00 drives its LED low; 01 releases it to high impedance.
// - Standby mode 10 blinks its LED at 0.5 Hz; 11 at 1 Hz.
// - Main LED mode sits in bits 5:4, read/write, resets to 00.
// - Main mode 00 holds its LED low; 01 leaves it high impedance.
// - Main mode 10 blinks its LED at 0.5 Hz; 11 at 1 Hz.
// - When both LEDs blink at the same rate, standby waveform is the inverse of main.
// - Bit 3 set routes the resume reset pin to general I/O 33.
// - Bit 2 set routes the power good pin to general I/O 32.
// - Bit 1 set routes the supply on pin to general I/O 31.
`timescale 1ns/10ps
`default_nettype none
module led_blink_pin_select #(
  parameter int TICK_CYC = led_pin_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Configuration register access
  input  wire led_pin_pkg::cfg_req_t cfg_req,
  output logic [7:0]                 cfg_rdata,
  output logic                       cfg_hit,
  // LED pads
  output led_pin_pkg::led_pin_t      standby_led_out,
  output led_pin_pkg::led_pin_t      main_led_out,
  // Multiplexed pins; bit 0 supply on, bit 1 power good, bit 2 resume
  input  wire logic [2:0]            func_o,
  input  wire logic [2:0]            func_oe_n,
  output logic      [2:0]            func_i,
  input  wire logic [2:0]            gpio_o,
  input  wire logic [2:0]            gpio_oe_n,
  output logic      [2:0]            gpio_i,
  input  wire logic [2:0]            pad_i,
  output logic      [2:0]            pad_o,
  output logic      [2:0]            pad_oe_n
);
  import led_pin_pkg::*;

  // Pad index of each multiplexed pin
  localparam int SON_PIN = SON_SEL_BIT - PIN_SEL_LO;
  localparam int PG_PIN  = PG_SEL_BIT - PIN_SEL_LO;
  localparam int RSM_PIN = RSM_SEL_BIT - PIN_SEL_LO;

  logic [7:0] sel2_r;
  logic [7:0] rdata_r;
  logic       hit_r;
  led_pin_t   stby_r;
  led_pin_t   main_r;
  led_mode_t  standby_led_mode;
  led_mode_t  main_led_mode;
  logic       phase_fast;
  logic       phase_slow;
  logic       sel_wr;
  logic       sel_rd;
  logic [PIN_COUNT-1:0] pin_sel;

  assign sel_wr = cfg_req.wr && (cfg_req.index == SEL2_INDEX);
  assign sel_rd = cfg_req.rd && (cfg_req.index == SEL2_INDEX);

  // Decoded fields of the select register
  assign standby_led_mode = led_mode_t'(sel2_r[STBY_MODE_HI:STBY_MODE_LO]);
  assign main_led_mode    = led_mode_t'(sel2_r[MAIN_MODE_HI:MAIN_MODE_LO]);
  assign pin_sel          = sel2_r[PIN_SEL_LO +: PIN_COUNT];

  // Select register; undefined bit 0 never stores
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel2_r <= SEL2_RESET;
    end else if (sel_wr) begin
      sel2_r <= cfg_req.wdata & SEL2_WMASK;
    end
  end

  // Read port: one cycle latency, unmapped index reads zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= sel_rd ? sel2_r : 8'h00;
      hit_r   <= sel_rd;
    end
  end

  assign cfg_rdata = rdata_r;
  assign cfg_hit   = hit_r;

  // One divider for both LEDs keeps their edges aligned
  blink_timebase #(
    .TICK_CYC   (TICK_CYC)
  ) u_timebase (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .phase_fast (phase_fast),
    .phase_slow (phase_slow)
  );

  // Pad value for one LED from its mode and blink phase
  function automatic led_pin_t led_drive(input led_mode_t mode,
                                         input logic fast,
                                         input logic slow);
    led_pin_t p;
    p = '{level: 1'b0, oe_n: 1'b0};
    unique case (mode)
      LED_LOW:  p = '{level: 1'b0, oe_n: 1'b0};
      LED_HIZ:  p = '{level: 1'b0, oe_n: 1'b1};
      LED_SLOW: p = '{level: slow, oe_n: 1'b0};
      LED_FAST: p = '{level: fast, oe_n: 1'b0};
    endcase
    return p;
  endfunction

  // Standby LED runs on inverted phases so it opposes the main LED
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stby_r <= '{level: 1'b0, oe_n: 1'b0};
    end else begin
      stby_r <= led_drive(standby_led_mode, ~phase_fast,
                          ~phase_slow);
    end
  end

  // Main LED uses the phases as they come
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_r <= '{level: 1'b0, oe_n: 1'b0};
    end else begin
      main_r <= led_drive(main_led_mode, phase_fast, phase_slow);
    end
  end

  assign standby_led_out = stby_r;
  assign main_led_out    = main_r;

  // Pin ownership follows bits 3:1
  pin_route #(
    .N         (PIN_COUNT)
  ) u_pins (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .gp_sel    (pin_sel),
    .func_o    (func_o),
    .func_oe_n (func_oe_n),
    .func_i    (func_i),
    .gpio_o    (gpio_o),
    .gpio_oe_n (gpio_oe_n),
    .gpio_i    (gpio_i),
    .pad_i     (pad_i),
    .pad_o     (pad_o),
    .pad_oe_n  (pad_oe_n)
  );

  // A write shows up in the standby field on the next read
  property p_stby_write;
    @(posedge clk_sys) disable iff (!rst_n)
      sel_wr ##1 sel_rd |=>
        cfg_rdata[STBY_MODE_HI:STBY_MODE_LO]
          == $past(cfg_req.wdata[STBY_MODE_HI:STBY_MODE_LO], 2);
  endproperty
  a_stby_write: assert property (p_stby_write)
    else $error("standby mode field did not keep the written value");

  property p_main_write;
    @(posedge clk_sys) disable iff (!rst_n)
      sel_wr |=> main_led_mode
        == led_mode_t'($past(cfg_req.wdata[MAIN_MODE_HI:MAIN_MODE_LO]));
  endproperty
  a_main_write: assert property (p_main_write)
    else $error("main mode field did not take the written value");

  // Bit 0 never reads back as one
  property p_bit0_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      hit_r |-> !cfg_rdata[0];
  endproperty
  a_bit0_zero: assert property (p_bit0_zero)
    else $error("undefined bit 0 read back set");

  // Read answer stands for exactly the cycle after a mapped read
  property p_hit_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) |-> cfg_hit == $past(sel_rd);
  endproperty
  a_hit_pulse: assert property (p_hit_pulse)
    else $error("read answer flag not one cycle after a mapped read");

  property p_read_data;
    @(posedge clk_sys) disable iff (!rst_n)
      cfg_hit |-> cfg_rdata == $past(sel2_r);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data differs from the select register");

  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      !cfg_hit |-> cfg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read answer");

  // Register only moves on a mapped write
  property p_reg_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) && !$past(sel_wr) |-> $stable(sel2_r);
  endproperty
  a_reg_hold: assert property (p_reg_hold)
    else $error("select register changed without a mapped write");

  property p_stby_static;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(standby_led_mode) == LED_LOW) |-> !stby_r.level && !stby_r.oe_n;
  endproperty
  a_stby_static: assert property (p_stby_static)
    else $error("standby LED not driven low in low mode");

  property p_stby_hiz;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(standby_led_mode) == LED_HIZ) |-> stby_r.oe_n;
  endproperty
  a_stby_hiz: assert property (p_stby_hiz)
    else $error("standby LED driven in high impedance mode");

  property p_stby_blink;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(standby_led_mode) == LED_FAST) && $changed(phase_fast)
        |=> ($past(standby_led_mode) == LED_FAST) |-> $changed(stby_r.level);
  endproperty
  a_stby_blink: assert property (p_stby_blink)
    else $error("standby LED missed a 1 Hz edge");

  // Standby blink levels are the inverted shared phases
  property p_stby_slow;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(standby_led_mode) == LED_SLOW)
        |-> stby_r.level == !$past(phase_slow) && !stby_r.oe_n;
  endproperty
  a_stby_slow: assert property (p_stby_slow)
    else $error("standby LED not following the inverted 0.5 Hz phase");

  property p_stby_fast;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(standby_led_mode) == LED_FAST)
        |-> stby_r.level == !$past(phase_fast) && !stby_r.oe_n;
  endproperty
  a_stby_fast: assert property (p_stby_fast)
    else $error("standby LED not following the inverted 1 Hz phase");

  property p_main_static;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(main_led_mode) == LED_LOW) |-> !main_r.level && !main_r.oe_n;
  endproperty
  a_main_static: assert property (p_main_static)
    else $error("main LED not held low in low mode");

  property p_main_hiz;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(main_led_mode) == LED_HIZ) |-> main_r.oe_n && !main_r.level;
  endproperty
  a_main_hiz: assert property (p_main_hiz)
    else $error("main LED driven in high impedance mode");

  property p_main_slow;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(main_led_mode) == LED_SLOW)
        |-> main_r.level == $past(phase_slow) && !main_r.oe_n;
  endproperty
  a_main_slow: assert property (p_main_slow)
    else $error("main LED not following the 0.5 Hz phase");

  property p_main_fast;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(main_led_mode) == LED_FAST)
        |-> main_r.level == $past(phase_fast) && !main_r.oe_n;
  endproperty
  a_main_fast: assert property (p_main_fast)
    else $error("main LED not following the 1 Hz phase");

  // Same blink rate on both means opposite levels every cycle
  property p_opposite;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(main_led_mode) == $past(standby_led_mode))
        && $past(main_led_mode[1])
        |-> stby_r.level != main_r.level;
  endproperty
  a_opposite: assert property (p_opposite)
    else $error("blinking LEDs not in opposite phase");

  // Each select bit owns the pin its position names, end to end
  property p_pad_resume;
    @(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) |-> pad_o[RSM_PIN] == ($past(sel2_r[RSM_SEL_BIT])
        ? $past(gpio_o[RSM_PIN]) : $past(func_o[RSM_PIN]));
  endproperty
  a_pad_resume: assert property (p_pad_resume)
    else $error("resume reset pin not routed by its select bit");

  property p_pad_power_good;
    @(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) |-> pad_o[PG_PIN] == ($past(sel2_r[PG_SEL_BIT])
        ? $past(gpio_o[PG_PIN]) : $past(func_o[PG_PIN]));
  endproperty
  a_pad_power_good: assert property (p_pad_power_good)
    else $error("power good pin not routed by its select bit");

  property p_pad_supply_on;
    @(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) |-> pad_o[SON_PIN] == ($past(sel2_r[SON_SEL_BIT])
        ? $past(gpio_o[SON_PIN]) : $past(func_o[SON_PIN]));
  endproperty
  a_pad_supply_on: assert property (p_pad_supply_on)
    else $error("supply on pin not routed by its select bit");

  c_stby_fast: cover property (@(posedge clk_sys) disable iff (!rst_n)
    standby_led_mode == LED_FAST ##1 $rose(stby_r.level));
  c_both_slow: cover property (@(posedge clk_sys) disable iff (!rst_n)
    standby_led_mode == LED_SLOW && main_led_mode == LED_SLOW
    ##1 $changed(main_r.level));
  c_gpio_sel: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sel_wr && cfg_req.wdata[RSM_SEL_BIT] ##2 !pad_oe_n[2]);
  c_main_hiz: cover property (@(posedge clk_sys) disable iff (!rst_n)
    main_led_mode == LED_HIZ ##1 main_r.oe_n);
  c_read_hit: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sel_wr ##1 sel_rd ##1 cfg_hit);

endmodule
`default_nettype wire

// ---- tb/led_blink_pin_select_test.sv ----
// Self-checking bench for the LED blink and pin select block
`timescale 1ns/10ps
`default_nettype none
module led_blink_pin_select_test;
  import led_pin_pkg::*;

  // Short tick so a full slow blink period is only sixteen cycles
  localparam int TICK = 4;

  logic       clk_sys;
  logic       rst_n;
  cfg_req_t   cfg_req;
  logic [7:0] cfg_rdata;
  logic       cfg_hit;
  led_pin_t   standby_led_out;
  led_pin_t   main_led_out;
  logic [2:0] func_o;
  logic [2:0] func_oe_n;
  logic [2:0] func_i;
  logic [2:0] gpio_o;
  logic [2:0] gpio_oe_n;
  logic [2:0] gpio_i;
  logic [2:0] pad_i;
  logic [2:0] pad_o;
  logic [2:0] pad_oe_n;
  logic [2:0] sel;
  int         failures;
  int         compares;

  led_blink_pin_select #(.TICK_CYC(TICK)) i_dut (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .cfg_req         (cfg_req),
    .cfg_rdata       (cfg_rdata),
    .cfg_hit         (cfg_hit),
    .standby_led_out (standby_led_out),
    .main_led_out    (main_led_out),
    .func_o          (func_o),
    .func_oe_n       (func_oe_n),
    .func_i          (func_i),
    .gpio_o          (gpio_o),
    .gpio_oe_n       (gpio_oe_n),
    .gpio_i          (gpio_i),
    .pad_i           (pad_i),
    .pad_o           (pad_o),
    .pad_oe_n        (pad_oe_n)
  );

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic finish_test;
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Caller stands at a rising edge; strobe lasts exactly one cycle
  task automatic cfg_write(input logic [7:0] idx, input logic [7:0] d);
    cfg_req.index <= idx;
    cfg_req.wdata <= d;
    cfg_req.wr    <= 1'b1;
    @(posedge clk_sys);
    cfg_req.wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the taking edge
  task automatic cfg_read(input logic [7:0] idx, input logic [7:0] exp,
                          input logic hit);
    cfg_req.index <= idx;
    cfg_req.rd    <= 1'b1;
    @(posedge clk_sys);
    cfg_req.rd    <= 1'b0;
    #1;
    check("cfg_rdata", cfg_rdata, exp);
    check("cfg_hit", {7'h00, cfg_hit}, {7'h00, hit});
    @(posedge clk_sys);
  endtask

  function automatic logic lvl(input bit sb);
    return sb ? standby_led_out.level : main_led_out.level;
  endfunction

  // First pass finds a toggle, second counts a full half period
  task automatic period(input bit sb, input int exp);
    logic prev;
    int   n;
    n = 0;
    @(posedge clk_sys);
    #1;
    for (int k = 0; k < 2; k++) begin
      prev = lvl(sb);
      n = 0;
      while (lvl(sb) === prev && n < 40) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
    end
    check(sb ? "standby half period" : "main half period", n[7:0],
          exp[7:0]);
    @(posedge clk_sys);
  endtask

  // Hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    finish_test();
  end

  initial begin
    failures  = 0;
    compares  = 0;
    rst_n     = 1'b0;
    cfg_req   = '0;
    func_o    = 3'h0;
    func_oe_n = 3'h7;
    gpio_o    = 3'h0;
    gpio_oe_n = 3'h7;
    pad_i     = 3'h0;
    sel       = 3'h0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("main reset", {6'h00, main_led_out}, 8'h00);
    check("standby reset", {6'h00, standby_led_out}, 8'h00);
    @(posedge clk_sys);
    cfg_read(SEL2_INDEX, 8'h00, 1'b1);
    // Back-to-back write and read; bit 0 is not stored
    cfg_write(SEL2_INDEX, 8'hff);
    cfg_read(SEL2_INDEX, 8'hfe, 1'b1);
    // Unmapped index must neither store nor answer
    cfg_write(8'h2b, 8'h55);
    cfg_read(SEL2_INDEX, 8'hfe, 1'b1);
    cfg_read(8'h2b, 8'h00, 1'b0);
    // Every LED mode, both outputs in the same mode
    for (int m = 0; m < 4; m++) begin
      cfg_write(SEL2_INDEX, {m[1:0], m[1:0], 4'h0});
      repeat (3) @(posedge clk_sys);
      #1;
      check("standby oe_n", {7'h00, standby_led_out.oe_n},
            {7'h00, m == 1});
      check("main oe_n", {7'h00, main_led_out.oe_n},
            {7'h00, m == 1});
      if (m == 0) begin
        check("standby low", {7'h00, standby_led_out.level}, 8'h00);
        check("main low", {7'h00, main_led_out.level}, 8'h00);
      end
      if (m >= 2)
        check("standby inverse", {7'h00, standby_led_out.level},
              {7'h00, ~main_led_out.level});
      @(posedge clk_sys);
      if (m >= 2) begin
        period(1'b0, m == 2 ? 2 * TICK : TICK);
        period(1'b1, m == 2 ? 2 * TICK : TICK);
      end
    end
    // All eight pin routings, with source values changing each pass
    for (int s = 0; s < 8; s++) begin
      sel = s[2:0];
      func_o    <= sel ^ 3'b101;
      func_oe_n <= sel ^ 3'b011;
      gpio_o    <= ~sel;
      gpio_oe_n <= sel ^ 3'b110;
      pad_i     <= sel ^ 3'b010;
      cfg_write(SEL2_INDEX, {4'h0, sel, 1'b0});
      repeat (3) @(posedge clk_sys);
      #1;
      check("pad_o", {5'h00, pad_o},
            {5'h00, (sel & gpio_o) | (~sel & func_o)});
      check("pad_oe_n", {5'h00, pad_oe_n},
            {5'h00, (sel & gpio_oe_n) | (~sel & func_oe_n)});
      check("func_i", {5'h00, func_i}, {5'h00, sel | pad_i});
      check("gpio_i", {5'h00, gpio_i}, {5'h00, ~sel | pad_i});
      @(posedge clk_sys);
    end
    // Reset in mid-run clears everything back to defaults
    cfg_write(SEL2_INDEX, 8'hde);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #1;
    check("main mid reset", {6'h00, main_led_out}, 8'h00);
    check("standby mid reset", {6'h00, standby_led_out}, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    cfg_read(SEL2_INDEX, 8'h00, 1'b1);
    finish_test();
  end

endmodule
`default_nettype wire
